//--- dcc_channel.sv
/*
 One DMA channel's control: enable, chaining, auto re-enable, event
 capture, priority, cell size and pointer, pattern terminate, and a
 Wishbone register slave with a masked interrupt.
 Assumes events, byte strobes and chain pulses come from logic on clk_i;
 arbitration between channels happens outside, fed by the grant input.
*/
// Decided for this implementation: register access over Wishbone and the register offsets.
//
// Contract
// - Active flag reads one while enabled or busy
// - Direction bit picks higher or lower chain partner
// - Direction matters only with chaining permitted
// - Transfers only while channel on bit set
// - Events while off recorded only if allowed
// - Chain enable accepted only if permitted
// - Auto re-enable keeps channel on after block
// - Event seen flag set by start event
// - Priority level equals two-bit field value
// - Cell size sets bytes per event
// - Cell pointer tracks cell, cleared on match
// - Pattern byte used only in terminate mode
// - Unimplemented upper bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module dcc_channel
   import dcc_pkg::*;
#(
   parameter int CELL_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic start_event_i,
   input wire logic abort_event_i,
   input wire logic chain_higher_done_i,
   input wire logic chain_lower_done_i,
   input wire logic grant_i,
   input wire logic byte_done_i,
   input wire logic [7:0] byte_data_i,
   input wire logic block_last_i,
   output logic request_o,
   output logic [1:0] channel_priority_level_o,
   output logic block_done_o,
   output logic irq_o
);
   logic channel_on;
   logic events_while_off_allow;
   logic chaining_permit;
   logic auto_reenable;
   logic chain_direction_select;
   logic [1:0] channel_priority_level;
   logic event_seen_flag;
   logic [CELL_W-1:0] cell_byte_count;
   logic [CELL_W-1:0] cell_progress_pointer;
   logic [7:0] match_byte;
   logic pattern_terminate_mode;
   logic [DCC_IRQ_BITS-1:0] irq_status;
   logic [DCC_IRQ_BITS-1:0] irq_mask;
   dcc_state_type state;
   logic channel_active_flag;
   logic wr;
   logic rd_hit;
   logic ctl_wr_lo;
   logic ctl_wr_hi;
   logic chain_fire;
   logic evt_accept;
   logic abort_accept;
   logic pattern_hit;
   logic cell_end;
   logic block_end;
   logic [DCC_IRQ_BITS-1:0] irq_set;
   logic [31:0] next_rdata;

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o;
   assign ctl_wr_lo = wr && wb_adr_i == DCC_OFS_CONTROL && wb_sel_i[0];
   assign ctl_wr_hi = wr && wb_adr_i == DCC_OFS_CONTROL && wb_sel_i[1];
   always_comb begin
      rd_hit = 1'b1;
      unique case (wb_adr_i)
         DCC_OFS_CONTROL, DCC_OFS_CELL_SIZE, DCC_OFS_CELL_POINTER,
         DCC_OFS_PATTERN_BYTE, DCC_OFS_MODE, DCC_OFS_IRQ_STATUS,
         DCC_OFS_IRQ_MASK: rd_hit = 1'b1;
         default: rd_hit = 1'b0;
      endcase
   end

   // Direction is only consulted once chaining is permitted
   assign chain_fire = chaining_permit && (chain_direction_select ?
      chain_higher_done_i : chain_lower_done_i);
   assign evt_accept = start_event_i &&
      (channel_on || events_while_off_allow);
   assign abort_accept = abort_event_i &&
      (channel_on || events_while_off_allow);
   assign pattern_hit = pattern_terminate_mode && byte_done_i &&
      state == DCC_MOVE && byte_data_i == match_byte;
   assign cell_end = state == DCC_MOVE && byte_done_i &&
      cell_progress_pointer + 1'b1 >= cell_byte_count;
   assign block_end = (cell_end && block_last_i) || pattern_hit;
   assign channel_active_flag = channel_on || state != DCC_IDLE;

   // Control bits; set by hardware wins over a software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_on <= 1'b0;
         events_while_off_allow <= 1'b0;
         chaining_permit <= 1'b0;
         auto_reenable <= 1'b0;
         chain_direction_select <= 1'b0;
         channel_priority_level <= DCC_PRIORITY_RESET;
      end else if (ce_i) begin
         if (ctl_wr_lo) begin
            channel_on <= wb_dat_i[DCC_BIT_ON];
            events_while_off_allow <= wb_dat_i[DCC_BIT_EVT_OFF];
            chaining_permit <= wb_dat_i[DCC_BIT_CHAIN_PERMIT];
            auto_reenable <= wb_dat_i[DCC_BIT_AUTO_REEN];
            channel_priority_level <= wb_dat_i[1:0];
         end
         if (ctl_wr_hi)
            chain_direction_select <= wb_dat_i[DCC_BIT_CHAIN_DIR];
         if ((block_end || abort_accept) && !auto_reenable)
            channel_on <= 1'b0;
         if (abort_accept && auto_reenable)
            channel_on <= 1'b0;
         if (chain_fire)
            channel_on <= 1'b1;
      end
   end

   // Pending start event; cleared when its cell begins or on abort
   always_ff @(posedge clk_i) begin
      if (rst_i)
         event_seen_flag <= 1'b0;
      else if (ce_i) begin
         if (evt_accept)
            event_seen_flag <= 1'b1;
         else if (abort_accept || (state == DCC_IDLE && request_o &&
                  grant_i))
            event_seen_flag <= 1'b0;
      end
   end

   // Cell state machine; a disable leaves MOVE through one DRAIN cycle to IDLE
   always_ff @(posedge clk_i) begin
      if (rst_i)
         state <= DCC_IDLE;
      else if (ce_i) begin
         unique case (state)
            DCC_IDLE:
               if (request_o && grant_i)
                  state <= DCC_MOVE;
            DCC_MOVE:
               if (abort_accept || cell_end || pattern_hit)
                  state <= DCC_IDLE;
               else if (!channel_on)
                  state <= DCC_DRAIN;
            DCC_DRAIN:
               state <= DCC_IDLE;
            default: state <= DCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         cell_progress_pointer <= '0;
      else if (ce_i) begin
         if (pattern_hit || abort_accept || cell_end)
            cell_progress_pointer <= '0;
         else if (state == DCC_MOVE && byte_done_i)
            cell_progress_pointer <= cell_progress_pointer + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cell_byte_count <= CELL_W'(DCC_CELL_SIZE_RESET);
         match_byte <= DCC_PATTERN_RESET;
         pattern_terminate_mode <= 1'b0;
         irq_mask <= '0;
      end else if (ce_i && wr) begin
         if (wb_adr_i == DCC_OFS_CELL_SIZE) begin
            if (wb_sel_i[0])
               cell_byte_count[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               cell_byte_count[CELL_W-1:8] <= wb_dat_i[CELL_W-1:8];
         end
         if (wb_adr_i == DCC_OFS_PATTERN_BYTE && wb_sel_i[0])
            match_byte <= wb_dat_i[7:0];
         if (wb_adr_i == DCC_OFS_MODE && wb_sel_i[0])
            pattern_terminate_mode <= wb_dat_i[0];
         if (wb_adr_i == DCC_OFS_IRQ_MASK && wb_sel_i[0])
            irq_mask <= wb_dat_i[DCC_IRQ_BITS-1:0];
      end
   end

   // Sticky status, write one to clear; a new event wins the cycle
   assign irq_set = {cell_end, pattern_hit, abort_accept, block_end};
   always_ff @(posedge clk_i) begin
      if (rst_i)
         irq_status <= '0;
      else if (ce_i) begin
         if (wr && wb_adr_i == DCC_OFS_IRQ_STATUS && wb_sel_i[0])
            irq_status <= (irq_status & ~wb_dat_i[DCC_IRQ_BITS-1:0]) |
               irq_set;
         else
            irq_status <= irq_status | irq_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         request_o <= 1'b0;
         channel_priority_level_o <= DCC_PRIORITY_RESET;
         block_done_o <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         // Arbiter outside ranks requests by this level, then number
         request_o <= channel_on && event_seen_flag && state == DCC_IDLE &&
            !(request_o && grant_i);
         channel_priority_level_o <= channel_priority_level;
         block_done_o <= block_end;
         irq_o <= |(irq_status & irq_mask);
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (wb_adr_i)
         DCC_OFS_CONTROL: begin
            next_rdata[DCC_BIT_ACTIVE] = channel_active_flag;
            next_rdata[DCC_BIT_CHAIN_DIR] = chain_direction_select;
            next_rdata[DCC_BIT_ON] = channel_on;
            next_rdata[DCC_BIT_EVT_OFF] = events_while_off_allow;
            next_rdata[DCC_BIT_CHAIN_PERMIT] = chaining_permit;
            next_rdata[DCC_BIT_AUTO_REEN] = auto_reenable;
            next_rdata[DCC_BIT_EVT_SEEN] = event_seen_flag;
            next_rdata[1:0] = channel_priority_level;
         end
         DCC_OFS_CELL_SIZE: next_rdata[CELL_W-1:0] = cell_byte_count;
         DCC_OFS_CELL_POINTER:
            next_rdata[CELL_W-1:0] = cell_progress_pointer;
         DCC_OFS_PATTERN_BYTE: next_rdata[7:0] = match_byte;
         DCC_OFS_MODE: next_rdata[0] = pattern_terminate_mode;
         DCC_OFS_IRQ_STATUS: next_rdata[DCC_IRQ_BITS-1:0] = irq_status;
         DCC_OFS_IRQ_MASK: next_rdata[DCC_IRQ_BITS-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // One-cycle answer; err on unmapped offsets
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
            rd_hit;
         wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
            !rd_hit;
         wb_dat_o <= next_rdata;
      end
   end
endmodule : dcc_channel
`default_nettype wire

//--- dcc_pkg.sv
/*
 Package for the DMA channel control block: register offsets, field
 positions, reset values and state types.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`default_nettype none
package dcc_pkg;
   localparam logic [7:0] DCC_OFS_CONTROL = 8'h00;
   localparam logic [7:0] DCC_OFS_CELL_SIZE = 8'h04;
   localparam logic [7:0] DCC_OFS_CELL_POINTER = 8'h08;
   localparam logic [7:0] DCC_OFS_PATTERN_BYTE = 8'h0c;
   localparam logic [7:0] DCC_OFS_MODE = 8'h10;
   localparam logic [7:0] DCC_OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] DCC_OFS_IRQ_MASK = 8'h18;
   localparam int DCC_BIT_ACTIVE = 15;
   localparam int DCC_BIT_CHAIN_DIR = 8;
   localparam int DCC_BIT_ON = 7;
   localparam int DCC_BIT_EVT_OFF = 6;
   localparam int DCC_BIT_CHAIN_PERMIT = 5;
   localparam int DCC_BIT_AUTO_REEN = 4;
   localparam int DCC_BIT_EVT_SEEN = 2;
   localparam int DCC_IRQ_BLOCK_DONE = 0;
   localparam int DCC_IRQ_ABORT = 1;
   localparam int DCC_IRQ_MATCH = 2;
   localparam int DCC_IRQ_CELL_DONE = 3;
   localparam int DCC_IRQ_BITS = 4;
   localparam logic [15:0] DCC_CELL_SIZE_RESET = 16'h0000;
   localparam logic [7:0] DCC_PATTERN_RESET = 8'h00;
   localparam logic [1:0] DCC_PRIORITY_RESET = 2'h0;
   typedef enum logic [1:0] {
      DCC_IDLE,
      DCC_MOVE,
      DCC_DRAIN
   } dcc_state_type;
endpackage : dcc_pkg
`default_nettype wire

//--- dcc_monitor.sv
/* Assertions on the DMA channel control ports.
   Bound from tb; sees only the ports of dcc_channel. */
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor
   import dcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic grant_i,
   input wire logic request_o,
   input wire logic [1:0] channel_priority_level_o,
   input wire logic block_done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic rd_ctl;
   assign take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
   assign rd_ctl = wb_ack_o && !wb_we_i && wb_adr_i == DCC_OFS_CONTROL;
   property p_answer; take |=> wb_ack_o || wb_err_o; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_single; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
   endproperty
   a_single: assert property (p_single) else $error("long ack");
   property p_unmap;
      take && wb_adr_i > DCC_OFS_IRQ_MASK |=> wb_err_o && !wb_ack_o;
   endproperty
   a_unmap: assert property (p_unmap) else $error("no error");
   property p_upper; wb_ack_o && !wb_we_i &&
      wb_adr_i <= DCC_OFS_PATTERN_BYTE |-> wb_dat_o[31:16] == 16'h0000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits");
   property p_prio; rd_ctl |-> wb_dat_o[1:0] == channel_priority_level_o;
   endproperty
   a_prio: assert property (p_prio) else $error("priority out");
   property p_active; rd_ctl && wb_dat_o[DCC_BIT_ON] |->
      wb_dat_o[DCC_BIT_ACTIVE]; endproperty
   a_active: assert property (p_active) else $error("active flag");
   property p_grant; request_o && grant_i && ce_i |=> !request_o;
   endproperty
   a_grant: assert property (p_grant) else $error("request held");
   property p_done; block_done_o |=> !block_done_o; endproperty
   a_done: assert property (p_done) else $error("done width");
   property p_reset; disable iff (1'b0) rst_i && ce_i |=> !request_o &&
      !block_done_o && channel_priority_level_o == 2'h0; endproperty
   a_reset: assert property (p_reset) else $error("reset value");
endmodule : dcc_monitor
`default_nettype wire

//--- dcc_partner.sv
/* Far side: arbiter grant plus a byte mover.
   Data runs on from one transfer to the next. */
`timescale 1ns/1ps
`default_nettype none
module dcc_partner (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic request_i,
   input wire logic slow_i,
   input wire logic [7:0] count_i,
   output logic grant_o,
   output logic byte_done_o,
   output logic [7:0] byte_data_o
);
   logic [7:0] left;
   logic [7:0] data;
   logic tick;
   // Idle data line shows the inverse of the next byte
   assign byte_data_o = byte_done_o ? data : ~data;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grant_o <= 1'b0;
         byte_done_o <= 1'b0;
         left <= 8'h00;
         data <= 8'hfe;
         tick <= 1'b0;
      end else begin
         tick <= !tick;
         grant_o <= request_i && !grant_o && left == 8'h00;
         byte_done_o <= 1'b0;
         if (byte_done_o) data <= data + 8'h01;
         if (grant_o && request_i) begin
            left <= count_i;
         end else if (left != 8'h00 && (!slow_i || tick)) begin
            byte_done_o <= 1'b1;
            left <= left - 8'h01;
         end
      end
   end
endmodule : dcc_partner
`default_nettype wire

//--- tb.sv
/* Self-checking bench for dcc_channel with the far-side model.
   Assumes the monitor and partner files compile first. */
`timescale 1ns/1ps
`default_nettype none
module tb
   import dcc_pkg::*;
;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, se = 0;
   logic chh = 0, chl = 0, slow = 0, ack, err, erred, grant, bd, req;
   logic ab = 0, ce = 1;
   logic done, irq;
   logic [7:0] adr = 0, count = 0, bdat;
   logic [3:0] sel = 0;
   logic [31:0] dw = 0, dr, q;
   logic [1:0] prio;
   int bad_count = 0, tests_run = 0, cycles = 0, nb;
   dcc_channel DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .wb_err_o(err), .start_event_i(se), .abort_event_i(ab),
      .chain_higher_done_i(chh), .chain_lower_done_i(chl),
      .grant_i(grant), .byte_done_i(bd), .byte_data_i(bdat),
      .block_last_i(1'b1), .request_o(req),
      .channel_priority_level_o(prio), .block_done_o(done), .irq_o(irq));
   dcc_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .request_i(req),
      .slow_i(slow), .count_i(count), .grant_o(grant), .byte_done_o(bd),
      .byte_data_o(bdat));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [3:0] s, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dw <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      q = dr;
      erred = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, 4'hf, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 4'hf, 32'h0);
   endtask : rd
   task automatic start_evt(input logic a = 1'b0);
      se <= !a;
      ab <= a;
      @(posedge clk_i);
      se <= 1'b0;
      ab <= 1'b0;
      @(posedge clk_i);
   endtask : start_evt
   task automatic wait_done;
      nb = 0;
      do begin
         @(posedge clk_i);
         if (bd === 1'b1) nb++;
      end while (done !== 1'b1);
   endtask : wait_done
   task automatic t_reset;
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i));
         chk("reset value", 32'h0, q);
      end
      rd(8'h40);
      chk("unmapped", 32'h1, {31'h0, erred});
   endtask : t_reset
   task automatic t_fields;
      wr(DCC_OFS_CONTROL, 32'hffff_ffff);
      rd(DCC_OFS_CONTROL);
      chk("control", 32'h81f3, q);
      wr(DCC_OFS_CONTROL, 32'h0);
      do rd(DCC_OFS_CONTROL); while (q[DCC_BIT_ACTIVE] !== 1'b0);
      chk("control off", 32'h0, q);
      wr(DCC_OFS_CELL_SIZE, 32'hffff_ffff);
      bus(1'b1, DCC_OFS_CELL_SIZE, 4'h2, 32'h0);
      rd(DCC_OFS_CELL_SIZE);
      chk("cell size", 32'h00ff, q);
      wr(DCC_OFS_PATTERN_BYTE, 32'hffff_ffff);
      rd(DCC_OFS_PATTERN_BYTE);
      chk("pattern", 32'hff, q);
      for (int k = 0; k < 4; k++) begin
         wr(DCC_OFS_CONTROL, 32'(k));
         chk("priority", 32'(k), {30'h0, prio});
      end
   endtask : t_fields
   task automatic t_chain;
      logic [31:0] ctl [5] = '{32'h120, 32'h120, 32'h120, 32'h20, 32'h0};
      logic [1:0] pls [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
      logic [4:0] on = 5'b01100;
      for (int i = 0; i < 5; i++) begin
         wr(DCC_OFS_CONTROL, ctl[i] & (i == 0 ? 32'h100 : 32'hfff));
         {chh, chl} <= (i == 0) ? 2'h2 : pls[i];
         @(posedge clk_i);
         {chh, chl} <= 2'h0;
         @(posedge clk_i);
         rd(DCC_OFS_CONTROL);
         chk("chain on", 32'(on[i]), 32'(q[DCC_BIT_ON]));
      end
   endtask : t_chain
   task automatic t_events;
      wr(DCC_OFS_CONTROL, 32'h0);
      start_evt;
      start_evt(1'b1);
      rd(DCC_OFS_CONTROL);
      chk("event off", 32'h0, 32'(q[DCC_BIT_EVT_SEEN]));
      rd(DCC_OFS_IRQ_STATUS);
      chk("abort off", 32'h0, q);
      wr(DCC_OFS_CONTROL, 32'h40);
      ce <= 1'b0;
      start_evt;
      ce <= 1'b1;
      rd(DCC_OFS_CONTROL);
      chk("frozen", 32'h0, 32'(q[DCC_BIT_EVT_SEEN]));
      start_evt(1'b1);
      rd(DCC_OFS_IRQ_STATUS);
      chk("abort kept", 32'h2, q);
      start_evt;
      rd(DCC_OFS_CONTROL);
      chk("event kept", 32'h1, 32'(q[DCC_BIT_EVT_SEEN]));
      chk("request off", 32'h0, 32'(req));
   endtask : t_events
   task automatic t_block;
      count <= 8'd4;
      wr(DCC_OFS_CELL_SIZE, 32'h4);
      wr(DCC_OFS_IRQ_MASK, 32'h1);
      wr(DCC_OFS_CONTROL, 32'h80);
      wait_done;
      chk("cell bytes", 32'd4, 32'(nb));
      rd(DCC_OFS_CONTROL);
      chk("on after block", 32'h0, 32'(q[DCC_BIT_ON]));
      chk("irq set", 32'h1, 32'(irq));
      wr(DCC_OFS_IRQ_MASK, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      wr(DCC_OFS_IRQ_MASK, 32'h1);
      wr(DCC_OFS_IRQ_STATUS, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
   endtask : t_block
   task automatic t_pattern;
      slow <= 1'b1;
      count <= 8'd8;
      wr(DCC_OFS_CELL_SIZE, 32'h8);
      wr(DCC_OFS_PATTERN_BYTE, 32'h04);
      wr(DCC_OFS_MODE, 32'h1);
      wr(DCC_OFS_CONTROL, 32'h90);
      start_evt;
      wait_done;
      chk("bytes to match", 32'd3, 32'(nb));
      rd(DCC_OFS_CELL_POINTER);
      chk("pointer", 32'h0, q);
      rd(DCC_OFS_CONTROL);
      chk("auto on", 32'h1, 32'(q[DCC_BIT_ON]));
   endtask : t_pattern
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_fields;
      t_chain;
      t_events;
      t_block;
      t_pattern;
      report_and_stop;
   end
endmodule : tb
bind dcc_channel dcc_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .grant_i(grant_i),
   .request_o(request_o), .block_done_o(block_done_o),
   .channel_priority_level_o(channel_priority_level_o));
`default_nettype wire
